// [hdl/jci_defs.svh]
// constants for the configuration instruction controller
`ifndef JCI_DEFS_SVH
`define JCI_DEFS_SVH

// instruction register
`define JCI_IR_W              8
`define JCI_IR_CAPTURE        8'h01
`define JCI_INSTR_BYPASS      8'hFF
`define JCI_INSTR_SIG_PROGRAM 8'h1A
`define JCI_INSTR_VERIFY_INCR 8'h2A
`define JCI_INSTR_SIG_READ    8'h17
`define JCI_INSTR_PROG_ENABLE 8'hC6
`define JCI_INSTR_PROG_DISABLE 8'h1E
`define JCI_INSTR_DONE_CLEAR  8'h24
`define JCI_INSTR_DONE_SET    8'h2F
`define JCI_INSTR_SEQ_RESET   8'h22
`define JCI_INSTR_IN1_CLEAR   8'h12
`define JCI_INSTR_IN1_SET     8'h13
`define JCI_INSTR_SAFE_OUT    8'h18

// widths
`define JCI_SIG_W             16
`define JCI_COL_W             16
`define JCI_ADDR_W            8
`define JCI_OD_N              14
`define JCI_HV_N              2

// reset values and the address step
`define JCI_DONE_INIT         1'b1
`define JCI_SIG_INIT          16'h0000
`define JCI_ADDR_ONE          8'h01

`endif

// [hdl/jci_pkg.sv]
// types shared by the configuration instruction controller
`include "jci_defs.svh"

package jci_pkg;

  // tap controller states, standard encoding
  typedef enum logic [3:0] {
    JCI_EX2DR = 4'h0, JCI_EX1DR = 4'h1, JCI_SHDR  = 4'h2, JCI_PDR   = 4'h3,
    JCI_SELDR = 4'h7, JCI_UPDR  = 4'h5, JCI_CAPDR = 4'h6, JCI_SELIR = 4'h4,
    JCI_EX2IR = 4'h8, JCI_EX1IR = 4'h9, JCI_SHIR  = 4'hA, JCI_PIR   = 4'hB,
    JCI_RTI   = 4'hC, JCI_UPIR  = 4'hD, JCI_CAPIR = 4'hE, JCI_TLR   = 4'hF
  } jci_tap_type;

  // sampled link pins
  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
  } jci_pins_type;

  // tap submodule state
  typedef struct packed {
    jci_tap_type tap;
  } jci_tap_state_type;

  // controller state
  typedef struct packed {
    jci_pins_type                pinS1;
    jci_pins_type                pinS2;
    jci_pins_type                pinS3;
    logic                        in1S1;
    logic                        in1S2;
    logic [`JCI_IR_W-1:0]        ir;
    logic [`JCI_IR_W-1:0]        irShift;
    logic [`JCI_SIG_W-1:0]       sigShift;
    logic [`JCI_SIG_W-1:0]       sigStore;
    logic [`JCI_COL_W-1:0]       colShift;
    logic                        bypass;
    logic [`JCI_ADDR_W-1:0]      addr;
    logic                        progMode;
    logic                        doneFlag;
    logic                        in1Bit;
    logic                        safe;
    logic                        seqReset;
    logic                        sigWrite;
    logic                        tdo;
    logic                        tdoEn;
    logic [`JCI_OD_N-1:0]        odOe;
    logic [`JCI_HV_N-1:0]        hvOut;
    logic                        seqIn1;
  } jci_ctrl_state_type;

endpackage

// [hdl/jci_tap.sv]
// tap state machine advanced on sampled tck rising edges
`timescale 1ns/1ps
`default_nettype none

module jci_tap
  import jci_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        tckRise,
  input  wire logic        tms,
  output jci_tap_type      tapState
);

  jci_tap_state_type q;
  jci_tap_state_type next_q;

  // next tap state from tms
  always_comb begin
    next_q = q;
    if (tckRise) begin
      unique case (q.tap)
        JCI_TLR:   next_q.tap = tms ? JCI_TLR   : JCI_RTI;
        JCI_RTI:   next_q.tap = tms ? JCI_SELDR : JCI_RTI;
        JCI_SELDR: next_q.tap = tms ? JCI_SELIR : JCI_CAPDR;
        JCI_CAPDR: next_q.tap = tms ? JCI_EX1DR : JCI_SHDR;
        JCI_SHDR:  next_q.tap = tms ? JCI_EX1DR : JCI_SHDR;
        JCI_EX1DR: next_q.tap = tms ? JCI_UPDR  : JCI_PDR;
        JCI_PDR:   next_q.tap = tms ? JCI_EX2DR : JCI_PDR;
        JCI_EX2DR: next_q.tap = tms ? JCI_UPDR  : JCI_SHDR;
        JCI_UPDR:  next_q.tap = tms ? JCI_SELDR : JCI_RTI;
        JCI_SELIR: next_q.tap = tms ? JCI_TLR   : JCI_CAPIR;
        JCI_CAPIR: next_q.tap = tms ? JCI_EX1IR : JCI_SHIR;
        JCI_SHIR:  next_q.tap = tms ? JCI_EX1IR : JCI_SHIR;
        JCI_EX1IR: next_q.tap = tms ? JCI_UPIR  : JCI_PIR;
        JCI_PIR:   next_q.tap = tms ? JCI_EX2IR : JCI_PIR;
        JCI_EX2IR: next_q.tap = tms ? JCI_UPIR  : JCI_SHIR;
        JCI_UPIR:  next_q.tap = tms ? JCI_SELDR : JCI_RTI;
      endcase
    end
  end

  // state register
  always_ff @(posedge clk) begin
    if (rst) begin
      q.tap <= JCI_TLR;
    end else begin
      q <= next_q;
    end
  end

  assign tapState = q.tap;

endmodule // jci_tap

`default_nettype wire

// [hdl/jci_ctrl.sv]
// configuration and sequencer instruction controller behind the test port
`timescale 1ns/1ps
`default_nettype none

`include "jci_defs.svh"

module jci_ctrl
  import jci_pkg::*;
(
  input  wire logic                   clk,
  input  wire logic                   rst,
  input  wire logic                   tck,
  input  wire logic                   tms,
  input  wire logic                   tdi,
  output logic                        tdo,
  output logic                        tdoEnable,
  input  wire logic                   in1Pin,
  input  wire logic                   in1FromPort,
  input  wire logic [`JCI_COL_W-1:0]  arrayColumn,
  output logic [`JCI_ADDR_W-1:0]      arrayAddr,
  input  wire logic [`JCI_OD_N-1:0]   macroPullLow,
  input  wire logic [`JCI_HV_N-1:0]   macroGateOn,
  output logic [`JCI_OD_N-1:0]        odOutEnable,
  output logic [`JCI_HV_N-1:0]        hvGateOut,
  output logic                        sequencerInputOne,
  output logic                        sequencerEnable,
  output logic                        sequenceReset,
  output logic                        programMode,
  output logic                        signatureWrite,
  output logic [`JCI_SIG_W-1:0]       userSignature
);

  jci_ctrl_state_type q;
  jci_ctrl_state_type next_q;
  jci_tap_type        tapState;
  logic               tckRise;
  logic               tckFall;

  // instructions that put the outputs in the safe state
  function automatic logic forcesSafe(input logic [`JCI_IR_W-1:0] op);
    forcesSafe = (op == `JCI_INSTR_SIG_PROGRAM) ||
                 (op == `JCI_INSTR_PROG_ENABLE) ||
                 (op == `JCI_INSTR_SAFE_OUT);
  endfunction

  // instructions that put the signature register on the scan path
  function automatic logic usesSig(input logic [`JCI_IR_W-1:0] op);
    usesSig = (op == `JCI_INSTR_SIG_READ) || (op == `JCI_INSTR_SIG_PROGRAM);
  endfunction

  // instructions that put the column register on the scan path
  function automatic logic usesCol(input logic [`JCI_IR_W-1:0] op);
    usesCol = (op == `JCI_INSTR_VERIFY_INCR);
  endfunction

  // edges of the synchronised tck, read after the second stage
  assign tckRise = q.pinS2.tck & ~q.pinS3.tck;
  assign tckFall = ~q.pinS2.tck & q.pinS3.tck;

  jci_tap u_tap (
    .clk      (clk),
    .rst      (rst),
    .tckRise  (tckRise),
    .tms      (q.pinS2.tms),
    .tapState (tapState)
  );

  // next state
  always_comb begin
    next_q          = q;

    // two-flop synchronisers, third tck stage only for edge finding
    next_q.pinS1    = '{tck: tck, tms: tms, tdi: tdi};
    next_q.pinS2    = q.pinS1;
    next_q.pinS3    = q.pinS2;
    next_q.in1S1    = in1Pin;
    next_q.in1S2    = q.in1S1;

    // strobes last one clock unless set again below
    next_q.seqReset = 1'b0;
    next_q.sigWrite = 1'b0;

    // capture and shift on tck rise
    if (tckRise) begin
      unique case (tapState)
        JCI_CAPIR: next_q.irShift = `JCI_IR_CAPTURE;
        JCI_SHIR:  next_q.irShift = {q.pinS2.tdi, q.irShift[`JCI_IR_W-1:1]};
        JCI_CAPDR: begin
          // unknown codes act as bypass, so their one-bit path captures too
          if (!usesSig(q.ir) && !usesCol(q.ir)) begin
            next_q.bypass = 1'b0;
          end
        end
        JCI_SHDR: begin
          if (usesSig(q.ir)) begin
            next_q.sigShift = {q.pinS2.tdi, q.sigShift[`JCI_SIG_W-1:1]};
          end else if (usesCol(q.ir)) begin
            next_q.colShift = {q.pinS2.tdi, q.colShift[`JCI_COL_W-1:1]};
          end else begin
            next_q.bypass = q.pinS2.tdi;
          end
        end
        default: begin
        end
      endcase
    end

    // tdo changes on tck fall, driven only while shifting
    if (tckFall) begin
      next_q.tdoEn = (tapState == JCI_SHIR) || (tapState == JCI_SHDR);
      if (tapState == JCI_SHIR) begin
        next_q.tdo = q.irShift[0];
      end else if (usesSig(q.ir)) begin
        next_q.tdo = q.sigShift[0];
      end else if (usesCol(q.ir)) begin
        next_q.tdo = q.colShift[0];
      end else begin
        next_q.tdo = q.bypass;
      end
    end

    // instruction takes effect at update-ir
    if (tckFall && tapState == JCI_UPIR) begin
      next_q.ir = q.irShift;
      unique case (q.irShift)
        `JCI_INSTR_SIG_PROGRAM: begin
          if (q.progMode) begin
            next_q.sigStore = q.sigShift;
            next_q.sigWrite = 1'b1;
          end
        end
        `JCI_INSTR_SIG_READ: begin
          // the store is copied so a read scan can show it
          next_q.sigShift = q.sigStore;
        end
        `JCI_INSTR_VERIFY_INCR: begin
          next_q.colShift = arrayColumn;
          next_q.addr     = q.addr + `JCI_ADDR_ONE;
        end
        `JCI_INSTR_PROG_ENABLE:  next_q.progMode = 1'b1;
        `JCI_INSTR_PROG_DISABLE: next_q.progMode = 1'b0;
        `JCI_INSTR_DONE_CLEAR:   next_q.doneFlag = 1'b0;
        `JCI_INSTR_DONE_SET:     next_q.doneFlag = 1'b1;
        `JCI_INSTR_SEQ_RESET:    next_q.seqReset = 1'b1;
        `JCI_INSTR_IN1_CLEAR:    next_q.in1Bit   = 1'b0;
        `JCI_INSTR_IN1_SET:      next_q.in1Bit   = 1'b1;
        default: begin
        end
      endcase
    end

    // test-logic-reset drops programming mode and selects bypass
    if (tapState == JCI_TLR) begin
      next_q.progMode = 1'b0;
      next_q.ir       = `JCI_INSTR_BYPASS;
      next_q.tdoEn    = 1'b0;
    end

    // safe output state follows the loaded instruction
    next_q.safe = forcesSafe(q.ir);
    // a reset strobe also drops the outputs for one clock
    if (q.safe || q.seqReset) begin
      next_q.odOe  = '0;
      next_q.hvOut = '0;
    end else begin
      next_q.odOe  = macroPullLow;
      next_q.hvOut = macroGateOn;
    end

    // input one source select
    next_q.seqIn1 = in1FromPort ? q.in1Bit : q.in1S2;
  end

  // state register
  always_ff @(posedge clk) begin
    if (rst) begin
      q          <= '0;
      q.pinS1.tck <= 1'b0;
      q.ir       <= `JCI_INSTR_BYPASS;
      // done flag and store stand for their non-volatile contents
      q.doneFlag <= `JCI_DONE_INIT;
      q.sigStore <= `JCI_SIG_INIT;
    end else begin
      q <= next_q;
    end
  end

  // outputs from flip-flops
  assign tdo               = q.tdo;
  assign tdoEnable         = q.tdoEn;
  assign arrayAddr         = q.addr;
  assign odOutEnable       = q.odOe;
  assign hvGateOut         = q.hvOut;
  assign sequencerInputOne = q.seqIn1;
  assign sequencerEnable   = q.doneFlag;
  assign sequenceReset     = q.seqReset;
  assign programMode       = q.progMode;
  assign signatureWrite    = q.sigWrite;
  assign userSignature     = q.sigStore;

endmodule // jci_ctrl

`default_nettype wire

// [bench/jci_jtag_host.sv]
// test-port controller model driving the link pins
`timescale 1ns/1ps
`default_nettype none

module jci_jtag_host (
  input  wire logic tdo,
  output var logic  tck,
  output var logic  tms,
  output var logic  tdi
);
  // link clock stands low between frames
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end

  // one tck period, tdo taken just before the rising edge
  task automatic step(input logic m, input logic d, output logic q);
    tms = m;
    tdi = d;
    #80 q = tdo;
    tck = 1'b1;
    #80 tck = 1'b0;
  endtask

  // five tms highs reach test-logic-reset, then settle in run-test-idle
  task automatic resetTap();
    logic q;
    repeat (5) step(1'b1, 1'b0, q);
    step(1'b0, 1'b0, q);
  endtask

  // ir or dr scan from run-test-idle back to run-test-idle, lsb first
  task automatic scan(input logic ir, input logic [15:0] din, input int n,
                      output logic [15:0] dout);
    logic q;
    dout = 16'h0000;
    step(1'b1, 1'b0, q);
    if (ir) step(1'b1, 1'b0, q);
    step(1'b0, 1'b0, q);
    step(1'b0, 1'b0, q);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], q);
      dout[i] = q;
    end
    // update, then idle; tdi no longer meaningful so it shows the inverse
    step(1'b1, ~din[n-1], q);
    step(1'b0, ~din[n-1], q);
  endtask
endmodule // jci_jtag_host

`default_nettype wire

// [bench/jci_ctrl_sva.sv]
// assertions for the configuration instruction controller
`timescale 1ns/1ps
`default_nettype none
`include "jci_defs.svh"

module jci_ctrl_sva (
  input wire logic                   clk,
  input wire logic                   rst,
  input wire logic                   in1Pin,
  input wire logic                   in1FromPort,
  input wire logic [`JCI_ADDR_W-1:0] arrayAddr,
  input wire logic [`JCI_OD_N-1:0]   odOutEnable,
  input wire logic [`JCI_HV_N-1:0]   hvGateOut,
  input wire logic                   sequencerInputOne,
  input wire logic                   sequenceReset,
  input wire logic                   programMode,
  input wire logic                   signatureWrite,
  input wire logic [`JCI_SIG_W-1:0]  userSignature
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  // signature store and its write pulse
  a_write_needs_mode: assert property (signatureWrite |-> programMode)
    else $error("signature write outside programming mode");
  a_write_once: assert property (signatureWrite |=> !signatureWrite)
    else $error("signature write pulse too long");
  a_store_on_write: assert property (
    !$stable(userSignature) |-> signatureWrite || $past(signatureWrite))
    else $error("signature store changed without write");
  a_safe_on_write: assert property (
    signatureWrite |-> ##[1:2] (!(|odOutEnable) && !(|hvGateOut)))
    else $error("outputs not safe during signature program");
  // sequence reset
  a_reset_once: assert property (sequenceReset |=> !sequenceReset)
    else $error("sequence reset pulse too long");
  a_reset_outputs: assert property (
    sequenceReset |-> ##[0:2] (!(|odOutEnable) && !(|hvGateOut)))
    else $error("outputs not reset by sequence reset");
  // input one from the pin, only once the whole pin pipeline is out of reset
  a_in1_from_pin: assert property (
    (!$past(in1FromPort) && !$past(rst) && !$past(rst, 2) && !$past(rst, 3))
    |-> sequencerInputOne == $past(in1Pin, 3))
    else $error("input one does not follow the pin");
  // the array address
  a_addr_step: assert property (
    !$stable(arrayAddr) |-> arrayAddr == $past(arrayAddr) + 8'h01)
    else $error("array address moved by other than one");
endmodule // jci_ctrl_sva

bind jci_ctrl jci_ctrl_sva i_sva (
  .clk(clk), .rst(rst), .in1Pin(in1Pin), .in1FromPort(in1FromPort), .arrayAddr(arrayAddr),
  .odOutEnable(odOutEnable), .hvGateOut(hvGateOut), .sequencerInputOne(sequencerInputOne),
  .sequenceReset(sequenceReset), .programMode(programMode), .signatureWrite(signatureWrite),
  .userSignature(userSignature)
);

`default_nettype wire

// [bench/jci_ctrl_test.sv]
// self-checking bench for the configuration instruction controller
`timescale 1ns/1ps
`default_nettype none
`include "jci_defs.svh"

module jci_ctrl_test;
  logic                   clk = 1'b0, rst = 1'b1, in1Pin = 1'b0, in1FromPort = 1'b0;
  logic [`JCI_COL_W-1:0]  arrayColumn;
  logic [`JCI_OD_N-1:0]   macroPullLow = 14'h3FFF;
  logic [`JCI_HV_N-1:0]   macroGateOn = 2'h3;
  logic                   tck, tms, tdi, tdo, tdoEn, seqIn1, seqEn, seqRst, progMode, sigWr;
  logic [`JCI_ADDR_W-1:0] arrayAddr;
  logic [`JCI_OD_N-1:0]   odOe;
  logic [`JCI_HV_N-1:0]   hvOut;
  logic [`JCI_SIG_W-1:0]  userSig;
  logic [15:0]            rd;
  int                     failCount = 0, numChecks = 0, resets = 0, writes = 0, shiftClks = 0;

  always #5 clk = ~clk;

  // array model: column data carries the address it was read from
  assign arrayColumn = {8'hC3, arrayAddr};

  jci_jtag_host i_host (.tdo(tdo), .tck(tck), .tms(tms), .tdi(tdi));
  jci_ctrl i_dut (
    .clk(clk), .rst(rst), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdoEnable(tdoEn),
    .in1Pin(in1Pin), .in1FromPort(in1FromPort), .arrayColumn(arrayColumn),
    .arrayAddr(arrayAddr), .macroPullLow(macroPullLow), .macroGateOn(macroGateOn),
    .odOutEnable(odOe), .hvGateOut(hvOut), .sequencerInputOne(seqIn1),
    .sequencerEnable(seqEn), .sequenceReset(seqRst), .programMode(progMode),
    .signatureWrite(sigWr), .userSignature(userSig)
  );

  // count one-clock pulses and the clocks with tdo driven
  always @(posedge clk) begin
    if (seqRst === 1'b1) resets++;
    if (sigWr === 1'b1) writes++;
    if (tdoEn === 1'b1) shiftClks++;
  end

  task automatic check(input string what, input logic [15:0] exp, got);
    numChecks++;
    if (exp !== got) begin
      failCount++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic closeOut();
    $display("checks %0d mismatches %0d", numChecks, failCount);
    if (failCount == 0 && numChecks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // scans an instruction, starting just after a clock edge
  task automatic ir(input logic [7:0] op);
    @(posedge clk) #1;
    i_host.scan(1'b1, {8'h00, op}, 8, rd);
  endtask

  task automatic tDone();
    ir(`JCI_INSTR_DONE_CLEAR);
    check("enable", 1'b0, seqEn);
    ir(`JCI_INSTR_DONE_SET);
    check("enable", 1'b1, seqEn);
  endtask

  task automatic tIn1();
    ir(`JCI_INSTR_IN1_SET);
    check("in1 pin", 1'b0, seqIn1);
    in1Pin = 1'b1;
    repeat (4) @(posedge clk);
    #1 check("in1 pin", 1'b1, seqIn1);
    in1FromPort = 1'b1;
    ir(`JCI_INSTR_IN1_CLEAR);
    check("in1", 1'b0, seqIn1);
    ir(`JCI_INSTR_IN1_SET);
    check("in1", 1'b1, seqIn1);
    in1FromPort = 1'b0;
    in1Pin = 1'b0;
  endtask

  // 16 bits at 16 clocks per tck period keep tdo driven for 256 clocks
  task automatic tVerify();
    logic [`JCI_ADDR_W-1:0] a;
    int                     s;
    a = arrayAddr;
    ir(`JCI_INSTR_VERIFY_INCR);
    check("addr", 16'(a + 8'h01), 16'(arrayAddr));
    s = shiftClks;
    @(posedge clk) #1;
    i_host.scan(1'b0, 16'h0000, 16, rd);
    check("column", {8'hC3, a}, rd);
    check("drive clks", 16'h0100, 16'(shiftClks - s));
    check("drive idle", 1'b0, tdoEn);
  endtask

  task automatic tSignature();
    int w;
    w = writes;
    ir(`JCI_INSTR_SIG_PROGRAM);
    check("refused", 16'(w), 16'(writes));
    check("od", 16'h0000, 16'(odOe));
    ir(`JCI_INSTR_PROG_ENABLE);
    check("mode", 1'b1, progMode);
    ir(`JCI_INSTR_SIG_READ);
    @(posedge clk) #1;
    i_host.scan(1'b0, 16'hA5C3, 16, rd);
    check("erased", 16'h0000, rd);
    ir(`JCI_INSTR_SIG_PROGRAM);
    check("signature", 16'hA5C3, userSig);
    check("writes", 16'(w + 1), 16'(writes));
    check("od", 16'h0000, 16'(odOe));
    check("hv", 16'h0000, 16'(hvOut));
    ir(`JCI_INSTR_SIG_READ);
    @(posedge clk) #1;
    i_host.scan(1'b0, 16'h0000, 16, rd);
    check("readback", 16'hA5C3, rd);
    @(posedge clk) #1;
    i_host.resetTap();
    check("mode", 1'b0, progMode);
    check("od", 16'(macroPullLow), 16'(odOe));
    ir(`JCI_INSTR_PROG_ENABLE);
    ir(`JCI_INSTR_PROG_DISABLE);
    check("mode", 1'b0, progMode);
    ir(`JCI_INSTR_SAFE_OUT);
    check("od", 16'h0000, 16'(odOe));
    check("hv", 16'h0000, 16'(hvOut));
    ir(`JCI_INSTR_BYPASS);
    check("hv", 16'(macroGateOn), 16'(hvOut));
  endtask

  task automatic tSeqReset();
    int r;
    r = resets;
    ir(`JCI_INSTR_SEQ_RESET);
    check("pulses", 16'(r + 1), 16'(resets));
  endtask

  // main sequence after two reset cycles
  initial begin
    repeat (2) @(posedge clk);
    #1 rst = 1'b0;
    i_host.resetTap();
    check("enable", 1'b1, seqEn);
    check("signature", 16'h0000, userSig);
    tDone();
    tIn1();
    tVerify();
    tVerify();
    tSignature();
    tSeqReset();
    closeOut();
  end

  // hang guard
  initial begin
    repeat (50000) @(posedge clk);
    failCount++;
    closeOut();
  end
endmodule // jci_ctrl_test

`default_nettype wire
